/* design/mfc_host_ctrl.sv */
// Host controller for the managed flash extended configuration bytes
// Notes on behaviour
// - Factory phase codes normal, loading, loaded, auto
// - Host never writes reserved factory phase values
// - No content writes after loaded phase set
// - Thermal acknowledgement written only as 0x01/0x10
// - Wake byte: unit 7:5, count 4:0
// - Unit zero means no wake-ups at all
// - Capability bit allows double-rate identity programming
// - Host only writes 0x01 to block select
// - Selector picks write protect or dynamic capacity
// - Host never writes selector above 0x01
//
// The implementer's own choice: the AHB-Lite register port.
module mfc_host_ctrl
   import mfc_pkg::*;
#(
   parameter int LINK_HALF = LINK_HALF_DEF
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Device link
   output logic             lnk_clk_o,
   output logic             lnk_req_o,
   output logic             lnk_wr_o,
   output logic [7:0]       lnk_idx_o,
   output logic [7:0]       lnk_wdata_o,
   input  wire logic        lnk_ack_i,
   input  wire logic        lnk_err_i,
   input  wire logic [7:0]  lnk_rdata_i,
   // Decoded device state
   output logic             content_wr_ok_o,
   output logic             wake_en_o,
   output logic [2:0]       wake_unit_o,
   output logic [4:0]       wake_count_o,
   output logic             id_prog_ddr_o,
   output logic             perf_capped_o
);
   typedef enum logic [1:0] {B_THERM, B_WAKE, B_DDR, B_RUN} mfc_boot_t;

   mfc_link_if lk ();

   mfc_boot_t   boot_r;
   logic        pend_r, start_r, op_wr_r;
   logic [7:0]  op_idx_r, op_dat_r;
   logic        dph_r, dwr_r;
   logic [7:0]  dadr_r;
   logic [31:0] hrdata_r;
   logic        dev_err_r, refused_r, lock_r, hk_cap_r;
   logic [7:0]  cfg_therm_r, wake_r, ddr_r, therm_r, phase_r, pcg_r, last_rd_r;
   logic        wr_cmd, wr_stat, wr_cfg, cmd_ok, done_ok;
   logic [7:0]  cmd_idx, cmd_dat, cmd_dat_fix;

   // Fields the device owns; the host never writes them
   function automatic logic is_ro(input logic [7:0] idx);
      return (idx == IDX_RELEASE) || (idx == IDX_BOOT_TMO) || (idx == IDX_ACC_BLK) ||
             (idx == IDX_PHYS_SIZE) || (idx == IDX_ID_DDR) || (idx == IDX_WAKE);
   endfunction : is_ro

   // Value check for fields with a closed set of legal codes
   function automatic logic val_ok(input logic [7:0] idx, input logic [7:0] v);
      unique case (idx)
         IDX_FACTORY:  return v <= PH_AUTO;
         IDX_THERMAL:  return (v == TH_CASE) || (v == TH_CASE_BOARD);
         IDX_PHYS_SEL: return v == PBS_NATIVE;
         IDX_PROTECT:  return v <= PCG_DYNCAP;
         IDX_ALERT_HI: return v == ZERO_BYTE;
         default:      return !is_ro(idx);
      endcase
   endfunction : val_ok

   mfc_link_eng #(
      .HALF        (LINK_HALF)
   ) u_eng (
      .core_clk_i  (core_clk_i),
      .srst_i      (srst_i),
      .lk          (lk),
      .lnk_clk_o   (lnk_clk_o),
      .lnk_req_o   (lnk_req_o),
      .lnk_wr_o    (lnk_wr_o),
      .lnk_idx_o   (lnk_idx_o),
      .lnk_wdata_o (lnk_wdata_o),
      .lnk_ack_i   (lnk_ack_i),
      .lnk_err_i   (lnk_err_i),
      .lnk_rdata_i (lnk_rdata_i)
   );

   // Zero wait states and always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_r;

   // Write strobes in the data phase
   assign wr_cmd  = dph_r && dwr_r && (dadr_r == OFS_CMD);
   assign wr_stat = dph_r && dwr_r && (dadr_r == OFS_STAT);
   assign wr_cfg  = dph_r && dwr_r && (dadr_r == OFS_CFG);
   assign cmd_idx = hwdata_i[7:0];
   assign cmd_dat = hwdata_i[CMD_DATA_LSB +: 8];

   // Alert mask: reserved bits stripped, urgent enable kept when capable
   always_comb begin
      cmd_dat_fix = cmd_dat;
      if (cmd_idx == IDX_ALERT_LO) begin
         cmd_dat_fix = cmd_dat & ALERT_LO_WMASK;
         cmd_dat_fix[URGENT_BIT] = hk_cap_r;
      end
   end

   // Software commands are taken only when idle, booted and legal
   assign cmd_ok = (boot_r == B_RUN) && !pend_r && !lk.busy &&
                   (!hwdata_i[CMD_WR_BIT] || val_ok(cmd_idx, cmd_dat));
   assign done_ok = lk.done && !lk.err;

   // Address phase capture and registered read data
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         dph_r    <= 1'b0;
         dwr_r    <= 1'b0;
         dadr_r   <= ZERO_BYTE;
         hrdata_r <= '0;
      end else begin
         dph_r <= hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
         if (hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ)) begin
            dwr_r    <= hwrite_i;
            dadr_r   <= haddr_i[7:0];
            hrdata_r <= '0;
            if (!hwrite_i) begin
               unique case (haddr_i[7:0])
                  OFS_STAT: begin
                     hrdata_r[ST_BUSY]      <= pend_r;
                     hrdata_r[ST_DEV_ERR]   <= dev_err_r;
                     hrdata_r[ST_REFUSED]   <= refused_r;
                     hrdata_r[ST_LOCK]      <= lock_r;
                     hrdata_r[ST_BOOT_DONE] <= (boot_r == B_RUN);
                     hrdata_r[ST_RDATA_LSB +: 8] <= last_rd_r;
                  end
                  OFS_INFO: begin
                     hrdata_r[IN_WAKE_LSB +: 8]  <= wake_r;
                     hrdata_r[IN_WAKE_EN]        <= wake_en_o;
                     hrdata_r[IN_DDR_OK]         <= id_prog_ddr_o;
                     hrdata_r[IN_PERF_CAP]       <= perf_capped_o;
                     hrdata_r[IN_DYNCAP]         <= (pcg_r == PCG_DYNCAP);
                     hrdata_r[IN_PHASE_LSB +: 8] <= phase_r;
                  end
                  OFS_CFG: begin
                     hrdata_r[7:0]       <= cfg_therm_r;
                     hrdata_r[CF_HK_CAP] <= hk_cap_r;
                  end
                  default: hrdata_r <= '0;
               endcase
            end
         end
      end
   end

   // Configuration; an illegal thermal value is ignored
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cfg_therm_r <= CFG_THERM_RST;
         hk_cap_r    <= 1'b0;
      end else if (wr_cfg) begin
         if (val_ok(IDX_THERMAL, hwdata_i[7:0])) begin
            cfg_therm_r <= hwdata_i[7:0];
         end
         hk_cap_r <= hwdata_i[CF_HK_CAP];
      end
   end

   // Command issue: boot sequence first, then software commands
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         start_r  <= 1'b0;
         pend_r   <= 1'b0;
         op_wr_r  <= 1'b0;
         op_idx_r <= ZERO_BYTE;
         op_dat_r <= ZERO_BYTE;
      end else begin
         start_r <= 1'b0;
         if (lk.done) begin
            pend_r <= 1'b0;
         end
         if ((boot_r != B_RUN) && !pend_r && !lk.busy) begin
            start_r <= 1'b1;
            pend_r  <= 1'b1;
            unique case (boot_r)
               B_THERM: begin
                  op_wr_r  <= 1'b1;
                  op_idx_r <= IDX_THERMAL;
                  op_dat_r <= cfg_therm_r;
               end
               B_WAKE: begin
                  op_wr_r  <= 1'b0;
                  op_idx_r <= IDX_WAKE;
               end
               default: begin
                  op_wr_r  <= 1'b0;
                  op_idx_r <= IDX_ID_DDR;
               end
            endcase
         end else if (wr_cmd && cmd_ok) begin
            start_r  <= 1'b1;
            pend_r   <= 1'b1;
            op_wr_r  <= hwdata_i[CMD_WR_BIT];
            op_idx_r <= cmd_idx;
            op_dat_r <= cmd_dat_fix;
         end
      end
   end

   assign lk.start = start_r;
   assign lk.wr    = op_wr_r;
   assign lk.idx   = op_idx_r;
   assign lk.wdata = op_dat_r;

   // Boot steps advance on each finished access, even a failed one
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         boot_r <= B_THERM;
      end else if (lk.done && (boot_r != B_RUN)) begin
         unique case (boot_r)
            B_THERM: boot_r <= B_WAKE;
            B_WAKE:  boot_r <= B_DDR;
            default: boot_r <= B_RUN;
         endcase
      end
   end

   // Sticky status; a new event wins over a write-one clear
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         dev_err_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         if (lk.done && lk.err) begin
            dev_err_r <= 1'b1;
         end else if (wr_stat && hwdata_i[ST_DEV_ERR]) begin
            dev_err_r <= 1'b0;
         end
         if (wr_cmd && !cmd_ok) begin
            refused_r <= 1'b1;
         end else if (wr_stat && hwdata_i[ST_REFUSED]) begin
            refused_r <= 1'b0;
         end
      end
   end

   // Shadows of device fields, updated only by successful accesses
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wake_r    <= ZERO_BYTE;
         ddr_r     <= ZERO_BYTE;
         therm_r   <= TH_NONE;
         phase_r   <= PH_NORMAL;
         pcg_r     <= ZERO_BYTE;
         last_rd_r <= ZERO_BYTE;
         lock_r    <= 1'b0;
      end else if (done_ok) begin
         if (!op_wr_r) begin
            last_rd_r <= lk.rdata;
         end
         unique case (op_idx_r)
            IDX_WAKE:    wake_r  <= lk.rdata;
            IDX_ID_DDR:  ddr_r   <= lk.rdata;
            IDX_THERMAL: therm_r <= op_wr_r ? op_dat_r : lk.rdata;
            IDX_PROTECT: pcg_r   <= op_wr_r ? op_dat_r : lk.rdata;
            IDX_FACTORY: begin
               // Auto phase returns to normal by itself; a read refreshes it
               phase_r <= op_wr_r ? op_dat_r : lk.rdata;
               lock_r  <= ((op_wr_r ? op_dat_r : lk.rdata) == PH_LOADED);
            end
            default: ;
         endcase
      end
   end

   // Decoded outputs for the system
   assign content_wr_ok_o = !lock_r;
   assign wake_unit_o     = wake_r[WAKE_UNIT_MSB:WAKE_UNIT_LSB];
   assign wake_count_o    = wake_r[WAKE_CNT_MSB:0];
   assign wake_en_o       = (wake_unit_o != WU_NONE) && (wake_unit_o <= WU_MINUTES);
   assign id_prog_ddr_o   = ddr_r[DDR_OK_BIT];
   assign perf_capped_o   = (therm_r == TH_NONE);

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   factory_code_a: assert property (lk.start && lk.wr && lk.idx == IDX_FACTORY |-> lk.wdata <= PH_AUTO)
      else $error("reserved factory phase written");
   thermal_code_a: assert property (lk.start && lk.wr && lk.idx == IDX_THERMAL |->
                                    lk.wdata == TH_CASE || lk.wdata == TH_CASE_BOARD)
      else $error("illegal thermal acknowledgement written");
   selector_code_a: assert property (lk.start && lk.wr && lk.idx == IDX_PROTECT |-> lk.wdata <= PCG_DYNCAP)
      else $error("reserved selector value written");
   block_sel_a: assert property (lk.start && lk.wr && lk.idx == IDX_PHYS_SEL |-> lk.wdata == PBS_NATIVE)
      else $error("block select written with other than native");
   boot_thermal_a: assert property ($fell(srst_i) |-> ##[1:3] lnk_req_o && lnk_wr_o && lnk_idx_o == IDX_THERMAL)
      else $error("thermal acknowledgement not written first");
   err_sticky_a: assert property (lk.done && lk.err |=> dev_err_r [*2])
      else $error("device write error not recorded");
   urgent_keep_a: assert property (lk.start && lk.wr && lk.idx == IDX_ALERT_LO && hk_cap_r |->
                                   lk.wdata[URGENT_BIT])
      else $error("urgent housekeeping enable dropped");
   wake_off_a: assert property (wake_unit_o == WU_NONE |-> !wake_en_o)
      else $error("wake enabled with zero unit");

   boot_done_c: cover property (boot_r == B_DDR ##1 boot_r == B_RUN);
   dev_err_c:   cover property (lk.done && lk.err);
   refused_c:   cover property (wr_cmd && !cmd_ok);
   lock_c:      cover property ($rose(lock_r));
endmodule : mfc_host_ctrl

/* design/mfc_link_eng.sv */
// Link engine: divided link clock and four-phase byte access handshake
module mfc_link_eng
   import mfc_pkg::*;
#(
   parameter int HALF = LINK_HALF_DEF
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       srst_i,
   // Command carrier
   mfc_link_if.eng         lk,
   // Link pins
   output logic            lnk_clk_o,
   output logic            lnk_req_o,
   output logic            lnk_wr_o,
   output logic [7:0]      lnk_idx_o,
   output logic [7:0]      lnk_wdata_o,
   input  wire logic       lnk_ack_i,
   input  wire logic       lnk_err_i,
   input  wire logic [7:0] lnk_rdata_i
);
   localparam int CW = $clog2(HALF) + 1;
   localparam logic [CW-1:0] HALF_LAST = CW'(HALF - 1);

   typedef enum logic [1:0] {E_IDLE, E_REQ, E_GRAB, E_REL} mfc_eng_t;
   mfc_eng_t         state_r;
   logic [CW-1:0]    div_r;
   logic             ack_m_r, ack_r, err_m_r, err_r;
   logic [7:0]       rd_m_r, rd_r;
   logic             done_r, lerr_r;
   logic [7:0]       lrd_r;

   // Link clock divider, free running from reset
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         div_r     <= '0;
         lnk_clk_o <= 1'b0;
      end else if (div_r == HALF_LAST) begin
         div_r     <= '0;
         lnk_clk_o <= ~lnk_clk_o;
      end else begin
         div_r     <= div_r + CW'(1);
      end
   end

   // Two-stage synchronisers; data is stable while ack is high
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ack_m_r <= 1'b0;
         ack_r   <= 1'b0;
         err_m_r <= 1'b0;
         err_r   <= 1'b0;
         rd_m_r  <= ZERO_BYTE;
         rd_r    <= ZERO_BYTE;
      end else begin
         ack_m_r <= lnk_ack_i;
         ack_r   <= ack_m_r;
         err_m_r <= lnk_err_i;
         err_r   <= err_m_r;
         rd_m_r  <= lnk_rdata_i;
         rd_r    <= rd_m_r;
      end
   end

   // Handshake; the extra grab cycle lets data settle after a skewed ack
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_r     <= E_IDLE;
         lnk_req_o   <= 1'b0;
         lnk_wr_o    <= 1'b0;
         lnk_idx_o   <= ZERO_BYTE;
         lnk_wdata_o <= ZERO_BYTE;
         done_r      <= 1'b0;
         lerr_r      <= 1'b0;
         lrd_r       <= ZERO_BYTE;
      end else begin
         done_r <= 1'b0;
         unique case (state_r)
            E_IDLE: begin
               if (lk.start) begin
                  state_r     <= E_REQ;
                  lnk_req_o   <= 1'b1;
                  lnk_wr_o    <= lk.wr;
                  lnk_idx_o   <= lk.idx;
                  lnk_wdata_o <= lk.wdata;
               end
            end
            E_REQ: begin
               if (ack_r) begin
                  state_r <= E_GRAB;
               end
            end
            E_GRAB: begin
               lerr_r    <= err_r;
               lrd_r     <= rd_r;
               lnk_req_o <= 1'b0;
               state_r   <= E_REL;
            end
            E_REL: begin
               if (!ack_r) begin
                  done_r  <= 1'b1;
                  state_r <= E_IDLE;
               end
            end
         endcase
      end
   end

   assign lk.busy  = (state_r != E_IDLE);
   assign lk.done  = done_r;
   assign lk.err   = lerr_r;
   assign lk.rdata = lrd_r;

   // Cycles since the link clock last moved, counted apart from the divider
   // so that the half-period check does not merely restate it
   logic          clk_q_r;
   logic [CW-1:0] since_r;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         clk_q_r <= 1'b0;
         since_r <= '0;
      end else begin
         clk_q_r <= lnk_clk_o;
         if (lnk_clk_o != clk_q_r) begin
            since_r <= '0;
         end else begin
            since_r <= since_r + CW'(1);
         end
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);

   req_hold_a: assert property (lnk_req_o && !ack_r |=> lnk_req_o)
      else $error("link request dropped before acknowledge");
   pins_stable_a: assert property (lnk_req_o && $past(lnk_req_o) |-> $stable(lnk_idx_o) && $stable(lnk_wdata_o))
      else $error("link index or data changed during request");
   clk_period_a: assert property ($changed(lnk_clk_o) |-> since_r >= HALF_LAST)
      else $error("link clock half period too short");
endmodule : mfc_link_eng

/* pkg/mfc_link_if.sv */
// Command carrier between the controller core and its link engine
interface mfc_link_if;
   logic       start;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic       busy;
   logic       done;
   logic       err;
   logic [7:0] rdata;
   modport ctrl (output start, wr, idx, wdata, input busy, done, err, rdata);
   modport eng  (input start, wr, idx, wdata, output busy, done, err, rdata);
endinterface : mfc_link_if

/* pkg/mfc_pkg.sv */
// Constants shared by the managed flash configuration host controller
package mfc_pkg;
   // Link clock: half period in core clock cycles (25 MHz core, 320 ns link period)
   localparam int          LINK_HALF_DEF  = 4;

   // Byte indices of the device's extended configuration fields
   localparam logic [7:0]  IDX_ALERT_LO   = 8'h38;
   localparam logic [7:0]  IDX_ALERT_HI   = 8'h39;
   localparam logic [7:0]  IDX_RELEASE    = 8'h3A;
   localparam logic [7:0]  IDX_PROTECT    = 8'h3B;
   localparam logic [7:0]  IDX_BOOT_TMO   = 8'h3C;
   localparam logic [7:0]  IDX_ACC_BLK    = 8'h3D;
   localparam logic [7:0]  IDX_PHYS_SEL   = 8'h3E;
   localparam logic [7:0]  IDX_PHYS_SIZE  = 8'h3F;
   localparam logic [7:0]  IDX_ID_DDR     = 8'h82;
   localparam logic [7:0]  IDX_WAKE       = 8'h83;
   localparam logic [7:0]  IDX_THERMAL    = 8'h84;
   localparam logic [7:0]  IDX_FACTORY    = 8'h85;

   // Field values
   localparam logic [7:0]  PH_NORMAL      = 8'h00;
   localparam logic [7:0]  PH_LOADING     = 8'h01;
   localparam logic [7:0]  PH_LOADED      = 8'h02;
   localparam logic [7:0]  PH_AUTO        = 8'h03;
   localparam logic [7:0]  TH_NONE        = 8'h00;
   localparam logic [7:0]  TH_CASE        = 8'h01;
   localparam logic [7:0]  TH_CASE_BOARD  = 8'h10;
   localparam logic [7:0]  PBS_NATIVE     = 8'h01;
   localparam logic [7:0]  PCG_DYNCAP     = 8'h01;
   localparam logic [7:0]  ALERT_LO_WMASK = 8'h1E;
   localparam logic [7:0]  ZERO_BYTE      = 8'h00;
   localparam int          URGENT_BIT     = 0;
   localparam int          DDR_OK_BIT     = 0;
   localparam int          WAKE_UNIT_MSB  = 7;
   localparam int          WAKE_UNIT_LSB  = 5;
   localparam int          WAKE_CNT_MSB   = 4;
   localparam logic [2:0]  WU_NONE        = 3'h0;
   localparam logic [2:0]  WU_MINUTES     = 3'h5;

   // Controller register offsets on the AHB-Lite slave
   localparam logic [7:0]  OFS_CMD        = 8'h00;
   localparam logic [7:0]  OFS_STAT       = 8'h04;
   localparam logic [7:0]  OFS_INFO       = 8'h08;
   localparam logic [7:0]  OFS_CFG        = 8'h0C;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

   // Command register fields
   localparam int          CMD_DATA_LSB   = 8;
   localparam int          CMD_WR_BIT     = 16;
   // Status register fields
   localparam int          ST_BUSY        = 0;
   localparam int          ST_DEV_ERR     = 1;
   localparam int          ST_REFUSED     = 2;
   localparam int          ST_LOCK        = 3;
   localparam int          ST_BOOT_DONE   = 4;
   localparam int          ST_RDATA_LSB   = 8;
   // Info register fields
   localparam int          IN_WAKE_LSB    = 0;
   localparam int          IN_WAKE_EN     = 8;
   localparam int          IN_DDR_OK      = 9;
   localparam int          IN_PERF_CAP    = 10;
   localparam int          IN_DYNCAP      = 11;
   localparam int          IN_PHASE_LSB   = 16;
   // Config register fields
   localparam int          CF_HK_CAP      = 8;
   localparam logic [7:0]  CFG_THERM_RST  = 8'h01;
endpackage : mfc_pkg

/* verification/mfc_dev_model.sv */
// Behavioural flash device holding the configuration bytes
module mfc_dev_model (
   // Clock, size strap and link
   input  wire logic       core_clk_i,
   input  wire logic       big_i,
   input  wire logic       req_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] idx_i,
   input  wire logic [7:0] wdata_i,
   output logic            ack_o = 1'b0,
   output logic            err_o = 1'b0,
   output logic [7:0]      rdata_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // Power-up bytes; urgent housekeeping and wake-ups (unit 2) start enabled
   logic [7:0] mem [256] = '{8'h38: 8'h01, 8'h3A: 8'h05, 8'h3C: 8'hFF, 8'h82: 8'h01,
                             8'h83: 8'h46, default: 8'h00};
   logic       bad;
   // Odd indices answer late, even ones promptly
   always @(posedge core_clk_i) begin
      if (req_i === 1'b1) begin
         repeat (idx_i[0] ? 6 : 1) @(posedge core_clk_i);
         bad = wr_i && (idx_i inside {8'h3A, 8'h3C, 8'h3D, 8'h3F, 8'h82, 8'h83} || idx_i == 8'h85 && wdata_i > 8'h03
               || idx_i == 8'h3B && wdata_i > 8'h01 || idx_i == 8'h3E && (!big_i || wdata_i != 8'h01));
         if (wr_i && !bad && idx_i != 8'h39)
            mem[idx_i] = idx_i == 8'h38 ? wdata_i & 8'h1E | 8'h01 : wdata_i;
         rdata_o <= idx_i == 8'h3F ? {7'h00, big_i} : mem[idx_i];
         err_o <= bad;
         ack_o <= 1'b1;
         do @(posedge core_clk_i); while (req_i === 1'b1);
         // Released lines flip so stale data is never taken as valid
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         err_o <= ~bad;
         if (mem[8'h85] == 8'h03)
            mem[8'h85] = 8'h00;
      end
   end
endmodule : mfc_dev_model

/* verification/test_managed_flash_ext_config_bytes.sv */
// Self-checking bench for the flash configuration host controller
module test_managed_flash_ext_config_bytes;
   timeunit 1ns;
   timeprecision 1ps;
   import mfc_pkg::*;
   logic        core_clk_i = 1'b0, srst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, big = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
   logic        hready, req, wr, ack, err, cwok, wen, ddr, cap;
   logic [7:0]  idx, wd, rd;
   logic [2:0]  wu;
   logic [4:0]  wc;
   int          fails = 0, tests_run = 0;

   mfc_host_ctrl #(.LINK_HALF(2)) mfc_host_ctrl_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(), .lnk_clk_o(), .lnk_req_o(req), .lnk_wr_o(wr),
      .lnk_idx_o(idx), .lnk_wdata_o(wd), .lnk_ack_i(ack), .lnk_err_i(err), .lnk_rdata_i(rd),
      .content_wr_ok_o(cwok), .wake_en_o(wen), .wake_unit_o(wu), .wake_count_o(wc), .id_prog_ddr_o(ddr),
      .perf_capped_o(cap));
   mfc_dev_model mfc_dev_model_i (.core_clk_i(core_clk_i), .big_i(big), .req_i(req), .wr_i(wr), .idx_i(idx),
      .wdata_i(wd), .ack_o(ack), .err_o(err), .rdata_o(rd));

   // 25 MHz clock
   always #20 core_clk_i = ~core_clk_i;

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict

   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", s, exp, seen);
      end
   endtask : chk

   // One AHB-Lite single word; read data lands in rdv
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
      int n = 0;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge core_clk_i); while (hready !== 1'b1 && ++n < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk_i); while (hready !== 1'b1 && ++n < 40);
      rdv = hrdata;
      if (n >= 40) begin
         fails++;
         give_verdict();
      end
   endtask : ahb

   // Bounded poll of one status bit
   task automatic poll(int b, logic v);
      int n = 0;
      do begin
         ahb(1'b0, OFS_STAT, 32'h0);
         n++;
      end while (rdv[b] !== v && n < 300);
      if (n >= 300) begin
         fails++;
         give_verdict();
      end
   endtask : poll

   // Clears sticky flags first so each order is judged alone
   task automatic cmd(logic w, logic [7:0] i, logic [7:0] d);
      ahb(1'b1, OFS_STAT, 32'h6);
      ahb(1'b1, OFS_CMD, {15'h0, w, d, i});
      repeat (3) @(posedge core_clk_i);
      poll(ST_BUSY, 1'b0);
   endtask : cmd

   task automatic t_boot();
      poll(ST_BOOT_DONE, 1'b1);
      chk("thermal", mfc_dev_model_i.mem[IDX_THERMAL], TH_CASE);
      chk("perf_cap", cap, 1'b0);
      chk("ddr_ok", ddr, 1'b1);
      cmd(1'b1, IDX_THERMAL, TH_NONE);
      chk("th_refused", rdv[ST_REFUSED], 1'b1);
      cmd(1'b1, IDX_THERMAL, TH_CASE_BOARD);
      chk("thermal2", mfc_dev_model_i.mem[IDX_THERMAL], TH_CASE_BOARD);
      // Every wake unit, reserved ones included
      for (int u = 0; u < 8; u++) begin
         mfc_dev_model_i.mem[IDX_WAKE] = {u[2:0], 5'h06};
         cmd(1'b0, IDX_WAKE, 8'h00);
         chk("wake_en", wen, u > 0 && u < 6);
         chk("wake_unit", {wu, wc}, {u[2:0], 5'h06});
      end
      $display("boot test done");
   endtask : t_boot

   task automatic t_phase();
      logic [7:0] ph [4] = '{PH_LOADING, PH_LOADED, PH_AUTO, PH_NORMAL};
      foreach (ph[k]) begin
         cmd(1'b1, IDX_FACTORY, ph[k]);
         chk("lock", cwok, ph[k] != PH_LOADED);
         cmd(1'b0, IDX_FACTORY, 8'h00);
         chk("phase", rdv[15:8], ph[k] == PH_AUTO ? PH_NORMAL : ph[k]);
      end
      cmd(1'b1, IDX_FACTORY, 8'h04);
      chk("ph_refused", rdv[ST_REFUSED], 1'b1);
      cmd(1'b1, IDX_PROTECT, PCG_DYNCAP);
      ahb(1'b0, OFS_INFO, 32'h0);
      chk("dyncap", rdv[IN_DYNCAP], 1'b1);
      cmd(1'b1, IDX_PROTECT, 8'h02);
      chk("sel_refused", rdv[ST_REFUSED], 1'b1);
      $display("phase test done");
   endtask : t_phase

   task automatic t_block();
      cmd(1'b1, IDX_PHYS_SEL, PBS_NATIVE);
      chk("dev_err", rdv[ST_DEV_ERR], 1'b1);
      big <= 1'b1;
      cmd(1'b1, IDX_PHYS_SEL, PBS_NATIVE);
      chk("sel", mfc_dev_model_i.mem[IDX_PHYS_SEL], PBS_NATIVE);
      cmd(1'b0, IDX_PHYS_SIZE, 8'h00);
      chk("size", rdv[15:8], 8'h01);
      cmd(1'b1, IDX_PHYS_SEL, 8'h00);
      chk("reenable", rdv[ST_REFUSED], 1'b1);
      ahb(1'b1, OFS_CFG, 32'h101);
      cmd(1'b1, IDX_ALERT_LO, 8'hFF);
      chk("mask", mfc_dev_model_i.mem[IDX_ALERT_LO], 8'h1F);
      cmd(1'b0, IDX_ALERT_HI, 8'h00);
      chk("mask_hi", rdv[15:8], 8'h00);
      cmd(1'b0, IDX_RELEASE, 8'h00);
      chk("release", rdv[15:8], 8'h05);
      cmd(1'b0, IDX_BOOT_TMO, 8'h00);
      chk("boot_tmo", rdv[15:8], 8'hFF);
      cmd(1'b1, IDX_RELEASE, 8'h11);
      chk("ro_refused", rdv[ST_REFUSED], 1'b1);
      ahb(1'b0, 8'h10, 32'h0);
      chk("unmapped", rdv, 32'h0);
      $display("block and alert test done");
   endtask : t_block

   initial begin
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      t_boot();
      t_phase();
      t_block();
      give_verdict();
   end
endmodule : test_managed_flash_ext_config_bytes
